// ### src/tccd_cc_detect.sv
// type-c cc comparator status, interrupt flags and autonomous role toggle
// Notes on behaviour
// R1: a change of level comparators or dac comparator raises its interrupt flag.
// R2: a 6-bit software dac threshold compares the selected cc line.
// R3: vbus has a fixed valid comparator; the dac may also measure vbus.
// R4: in toggle mode the block drives pull-ups, pull-downs and measure selects itself.
// R5: toggle may present source only or sink only, polling both cc pins.
// R6: on resolved role, raise toggle-done flag and report role and orientation.
// R7: with toggle off, terminations and measure selects follow software directly.
// R8: software sets default current, vconn off, masks before enabling toggle.
// R9: software clears pending flags before setting toggle enable.
// R10: vbus-valid interrupt and status report sink attach (1) and detach (0).
// R11: level status is 00 ra, 01 usb, 10 1.5a, 11 3.0a.
// R12: software classifies ra or rd from level and comparator results.
// R13: a current change before attach is presented once attached.
// R14: a current change while attached switches the pull-up at once.
// R15: software picks source dac thresholds; comparator 0 is attach.
// R16: software checks ra levels and dac thresholds as a source.
// R17: active-low open-drain interrupt output prompts the processor.
// R18: interrupt holds while any unmasked flag pends, releases when all cleared.
`timescale 1ns/1ps
module tccd_cc_detect
    import tccd_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    // analog comparator outputs, asynchronous
    input wire logic [2:0] level_cmp_raw,
    input wire logic dac_cmp_raw,
    input wire logic vbus_valid_raw,
    input wire logic toggle_en,
    input wire logic [1:0] toggle_mode,
    input wire logic sw_pulldown_en_a,
    input wire logic sw_pulldown_en_b,
    input wire logic sw_pullup_en_a,
    input wire logic sw_pullup_en_b,
    input wire logic sw_measure_sel_a,
    input wire logic sw_measure_sel_b,
    input wire logic sw_measure_sel_vbus,
    input wire logic [5:0] sw_dac_threshold,
    input wire logic [1:0] source_current_sel,
    input wire logic [3:0] irq_mask,
    input wire logic [3:0] irq_clear,
    // analog front-end controls
    output logic pulldown_en_a,
    output logic pulldown_en_b,
    output logic pullup_en_a,
    output logic pullup_en_b,
    output logic measure_sel_a,
    output logic measure_sel_b,
    output logic measure_sel_vbus,
    output logic [5:0] dac_threshold,
    output logic [1:0] cc_source_current,
    output logic [1:0] cc_current_level,
    output logic dac_cmp_status,
    output logic vbus_valid,
    output logic [2:0] toggle_result_state,
    output logic [3:0] irq_flags,
    output logic int_n_o,
    output logic int_n_oe
);

    // highest set comparator wins, so a broken thermometer code reads high
    function automatic logic [1:0] level_encode(input logic [2:0] therm);
        return therm[2] ? LVL_3A0 : (therm[1] ? LVL_1A5 : (therm[0] ? LVL_USB : LVL_RA));
    endfunction : level_encode

    function automatic logic [5:0] src_thresh(input logic [1:0] cur);
        return (cur == CUR_3A0) ? SRC_THRESH_HIGH : SRC_THRESH_LOW;
    endfunction : src_thresh

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers: stage one feeds stage two only
    logic [4:0] sync_a;
    logic [4:0] sync_b;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            {sync_b, sync_a} <= 10'h000;
        else
            {sync_b, sync_a} <= {sync_a, vbus_valid_raw, dac_cmp_raw, level_cmp_raw};
    end

    logic [1:0] next_level;
    logic level_chg;
    logic comp_chg;
    logic vbus_chg;

    assign next_level = level_encode(sync_b[2:0]);
    assign level_chg = next_level != cc_current_level;
    assign comp_chg = sync_b[3] != dac_cmp_status;
    assign vbus_chg = sync_b[4] != vbus_valid;

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cc_current_level <= LVL_RA;
            dac_cmp_status <= 1'b0;
            vbus_valid <= 1'b0;
        end
        else
        begin
            cc_current_level <= next_level; // R11
            dac_cmp_status <= sync_b[3]; // R2
            vbus_valid <= sync_b[4]; // R3 R10
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // autonomous toggle
    tccd_state_t state;
    tccd_state_t next_poll;
    logic [DWELL_W-1:0] dwell;
    logic polling;
    logic src_phase;
    logic on_a;
    logic hit;
    logic done_evt;

    assign polling = (state == ST_SRC_A) || (state == ST_SRC_B) ||
                     (state == ST_SNK_A) || (state == ST_SNK_B);
    assign src_phase = (state == ST_SRC_A) || (state == ST_SRC_B);
    assign on_a = (state == ST_SRC_A) || (state == ST_SNK_A);
    // source sees rd as comparator low; sink sees any rp above ra range
    assign hit = src_phase ? !dac_cmp_status : (cc_current_level != LVL_RA);
    assign done_evt = toggle_en && polling && (dwell == DWELL_LAST) && hit; // R6

    always_comb
    begin
        case (state)
            ST_SRC_A: next_poll = ST_SRC_B;
            ST_SRC_B: next_poll = (toggle_mode == MODE_DRP) ? ST_SNK_A : ST_SRC_A; // R4 R5
            ST_SNK_A: next_poll = ST_SNK_B;
            ST_SNK_B: next_poll = (toggle_mode == MODE_DRP) ? ST_SRC_A : ST_SNK_A; // R4 R5
            default: next_poll = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst || !toggle_en)
        begin
            state <= ST_IDLE;
            dwell <= '0;
            toggle_result_state <= RES_NONE;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    state <= (toggle_mode == MODE_SNK) ? ST_SNK_A : ST_SRC_A; // R5
                    dwell <= '0;
                end
                ST_SRC_A, ST_SRC_B, ST_SNK_A, ST_SNK_B:
                begin
                    if (dwell == DWELL_LAST)
                    begin
                        dwell <= '0;
                        if (hit)
                        begin
                            state <= ST_DONE;
                            case (state)
                                ST_SRC_A: toggle_result_state <= RES_SRC_A; // R6
                                ST_SRC_B: toggle_result_state <= RES_SRC_B;
                                ST_SNK_A: toggle_result_state <= RES_SNK_A;
                                default: toggle_result_state <= RES_SNK_B;
                            endcase
                        end
                        else
                            state <= next_poll;
                    end
                    else
                        dwell <= dwell + 1'b1;
                end
                ST_DONE: state <= ST_DONE;
                default: state <= ST_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // front-end drive: toggle logic or software
    logic res_src;
    logic res_a;

    assign res_src = (toggle_result_state == RES_SRC_A) || (toggle_result_state == RES_SRC_B);
    assign res_a = (toggle_result_state == RES_SRC_A) || (toggle_result_state == RES_SNK_A);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            {pulldown_en_a, pulldown_en_b, pullup_en_a, pullup_en_b} <= 4'h0;
            {measure_sel_a, measure_sel_b, measure_sel_vbus} <= 3'h0;
            dac_threshold <= 6'h00;
        end
        else if (!toggle_en)
        begin
            pulldown_en_a <= sw_pulldown_en_a; // R7
            pulldown_en_b <= sw_pulldown_en_b; // R7
            pullup_en_a <= sw_pullup_en_a; // R7
            pullup_en_b <= sw_pullup_en_b; // R7
            measure_sel_a <= sw_measure_sel_a; // R7
            measure_sel_b <= sw_measure_sel_b; // R7
            measure_sel_vbus <= sw_measure_sel_vbus; // R3
            dac_threshold <= sw_dac_threshold; // R2
        end
        else if (state == ST_DONE)
        begin
            // hold the winning termination on the oriented pin only
            pulldown_en_a <= !res_src && res_a;
            pulldown_en_b <= !res_src && !res_a;
            pullup_en_a <= res_src && res_a;
            pullup_en_b <= res_src && !res_a;
            measure_sel_a <= res_a;
            measure_sel_b <= !res_a;
            measure_sel_vbus <= 1'b0;
            dac_threshold <= res_src ? src_thresh(source_current_sel) : sw_dac_threshold;
        end
        else
        begin
            pulldown_en_a <= polling && !src_phase; // R4
            pulldown_en_b <= polling && !src_phase; // R4
            pullup_en_a <= src_phase; // R4
            pullup_en_b <= src_phase; // R4
            measure_sel_a <= polling && on_a; // R4
            measure_sel_b <= polling && !on_a; // R4
            measure_sel_vbus <= 1'b0;
            dac_threshold <= src_phase ? src_thresh(source_current_sel) : sw_dac_threshold;
        end
    end

    // pull-up current tracks the setting every cycle, attached or not
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            cc_source_current <= CUR_DEFAULT;
        else
            cc_source_current <= source_current_sel; // R13 R14
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky flags: a set in the clearing cycle wins
    logic [IRQ_W-1:0] irq_set;
    assign irq_set = {done_evt, vbus_chg, comp_chg, level_chg};
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            irq_flags <= IRQ_RESET;
        else
            irq_flags <= (irq_flags & ~irq_clear) | irq_set; // R1 R6 R10
    end

    // open drain: only ever pulls low
    assign int_n_o = 1'b0; // R17
    assign int_n_oe = |(irq_flags & ~irq_mask); // R17 R18

    ////////////////////////////////////////////////////////////////////////////
    level_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        $changed(cc_current_level) |-> irq_flags[IRQ_LEVEL])
        else $error("level change did not raise flag");
    comp_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        $changed(dac_cmp_status) |-> irq_flags[IRQ_COMP])
        else $error("comparator change did not raise flag");
    vbus_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
        $changed(vbus_valid) |-> irq_flags[IRQ_VBUS])
        else $error("vbus change did not raise flag");
    toggle_done_a: assert property (@(posedge clk) disable iff (sys_rst) // R6
        (state == ST_DONE) && ($past(state) != ST_DONE)
        |-> irq_flags[IRQ_TOGDONE] && (toggle_result_state != RES_NONE))
        else $error("resolved toggle without flag or result");
    manual_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // R7
        !toggle_en |=> (pullup_en_a == $past(sw_pullup_en_a))
            && (pulldown_en_b == $past(sw_pulldown_en_b))
            && (measure_sel_a == $past(sw_measure_sel_a)))
        else $error("manual controls not passed through");
    src_phase_a: assert property (@(posedge clk) disable iff (sys_rst) // R4
        toggle_en && (state == ST_SRC_B) |=> pullup_en_a && pullup_en_b
            && !pulldown_en_a && measure_sel_b && !measure_sel_a)
        else $error("source phase drive wrong");
    src_only_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
        toggle_en && (toggle_mode == MODE_SRC) && (state == ST_SRC_B)
            && (dwell == DWELL_LAST) && !hit |=> (state == ST_SRC_A))
        else $error("source only mode entered sink phase");
    int_level_a: assert property (@(posedge clk) disable iff (sys_rst) // R18
        int_n_oe == |(irq_flags & ~irq_mask))
        else $error("interrupt pin does not match pending flags");
    cur_follow_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
        ##1 cc_source_current == $past(source_current_sel))
        else $error("pull-up current did not follow setting");
    set_wins_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
        level_chg && irq_clear[IRQ_LEVEL] |=> irq_flags[IRQ_LEVEL])
        else $error("clear beat a simultaneous level event");

endmodule : tccd_cc_detect

// ### src/tccd_pkg.sv
// constants and types for the type-c cc detection and toggle block
package tccd_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // least dwell in each toggle phase, rounded up to whole cycles
    localparam int TOGGLE_DWELL_NS = 10000;
    localparam int TOGGLE_DWELL_CYC = (TOGGLE_DWELL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DWELL_W = 10;
    localparam logic [DWELL_W-1:0] DWELL_LAST = DWELL_W'(TOGGLE_DWELL_CYC - 1);

    localparam int DAC_W = 6;
    localparam logic [DAC_W-1:0] SRC_THRESH_LOW = 6'h25;
    localparam logic [DAC_W-1:0] SRC_THRESH_HIGH = 6'h3D;
    localparam logic [DAC_W-1:0] SNK_3A0_THRESH = 6'h34;

    localparam logic [1:0] CUR_DEFAULT = 2'h1;
    localparam logic [1:0] CUR_1A5 = 2'h2;
    localparam logic [1:0] CUR_3A0 = 2'h3;

    localparam logic [1:0] LVL_RA = 2'h0;
    localparam logic [1:0] LVL_USB = 2'h1;
    localparam logic [1:0] LVL_1A5 = 2'h2;
    localparam logic [1:0] LVL_3A0 = 2'h3;

    localparam int IRQ_W = 4;
    localparam int IRQ_LEVEL = 0;
    localparam int IRQ_COMP = 1;
    localparam int IRQ_VBUS = 2;
    localparam int IRQ_TOGDONE = 3;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

    localparam logic [2:0] RES_NONE = 3'h0;
    localparam logic [2:0] RES_SRC_A = 3'h1;
    localparam logic [2:0] RES_SRC_B = 3'h2;
    localparam logic [2:0] RES_SNK_A = 3'h5;
    localparam logic [2:0] RES_SNK_B = 3'h6;

    typedef enum logic [1:0] {
        MODE_DRP = 2'b00,
        MODE_SRC = 2'b01,
        MODE_SNK = 2'b10
    } tccd_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SRC_A = 3'b001,
        ST_SRC_B = 3'b010,
        ST_SNK_A = 3'b011,
        ST_SNK_B = 3'b100,
        ST_DONE = 3'b101
    } tccd_state_t;
endpackage : tccd_pkg

// ### bench/tccd_partner.sv
// attached type-c port partner model on the cc pins and vbus
`timescale 1ns/1ps
module tccd_partner (
    input wire logic pullup_en_a,
    input wire logic pullup_en_b,
    input wire logic measure_sel_a,
    input wire logic measure_sel_b,
    input wire logic [1:0] src_code,
    input wire logic src_on_b,
    input wire logic rd_en,
    input wire logic rd_on_b,
    input wire logic vbus_on,
    output logic [2:0] level_cmp_raw,
    output logic dac_cmp_raw,
    output logic vbus_valid_raw
);
    logic meas_b;
    logic meas_any;
    logic pulled;
    logic rd_here;
    logic src_here;

    always_comb
    begin
        meas_b = measure_sel_b && !measure_sel_a;
        meas_any = measure_sel_a || measure_sel_b;
        pulled = meas_b ? pullup_en_b : pullup_en_a;
        rd_here = rd_en && (rd_on_b == meas_b) && meas_any;
        src_here = (src_code != 2'h0) && (src_on_b == meas_b) && meas_any;
        // rd divides the pull-up below threshold; an open line rises above it
        dac_cmp_raw = pulled && !rd_here;
        // thermometer code, zero when the source sits on the other pin
        case (src_here ? src_code : 2'h0)
            2'h1: level_cmp_raw = 3'h1;
            2'h2: level_cmp_raw = 3'h3;
            2'h3: level_cmp_raw = 3'h7;
            default: level_cmp_raw = 3'h0;
        endcase
        vbus_valid_raw = vbus_on && (src_code != 2'h0);
    end
endmodule : tccd_partner

// ### bench/tb_top.sv
// self-checking testbench for the cc detection and toggle block
`timescale 1ns/1ps
module tb_top;
    import tccd_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic toggle_en = 1'b0;
    logic [1:0] toggle_mode = 2'h0;
    logic [6:0] sw = 7'h0;
    logic [5:0] sw_thr = 6'h0;
    logic [1:0] cur_sel = 2'h1;
    logic [3:0] irq_mask = 4'h0;
    logic [3:0] irq_clear = 4'h0;
    logic [1:0] src_code = 2'h0;
    logic src_on_b = 1'b0;
    logic rd_en = 1'b0;
    logic rd_on_b = 1'b0;
    logic vbus_on = 1'b0;
    logic pd_a, pd_b, pu_a, pu_b, ms_a, ms_b, ms_v, dac_st, vbus_valid, int_n_o, int_n_oe;
    logic dac_cmp_raw, vbus_valid_raw;
    logic [2:0] level_cmp_raw, result;
    logic [5:0] dac_thr;
    logic [1:0] cc_cur, level;
    logic [3:0] flags;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;

    tccd_cc_detect DUT (.clk(clk), .sys_rst(sys_rst), .level_cmp_raw(level_cmp_raw),
        .dac_cmp_raw(dac_cmp_raw), .vbus_valid_raw(vbus_valid_raw), .toggle_en(toggle_en),
        .toggle_mode(toggle_mode), .sw_pulldown_en_a(sw[6]), .sw_pulldown_en_b(sw[5]),
        .sw_pullup_en_a(sw[4]), .sw_pullup_en_b(sw[3]), .sw_measure_sel_a(sw[2]),
        .sw_measure_sel_b(sw[1]), .sw_measure_sel_vbus(sw[0]), .sw_dac_threshold(sw_thr),
        .source_current_sel(cur_sel), .irq_mask(irq_mask), .irq_clear(irq_clear),
        .pulldown_en_a(pd_a), .pulldown_en_b(pd_b), .pullup_en_a(pu_a), .pullup_en_b(pu_b),
        .measure_sel_a(ms_a), .measure_sel_b(ms_b), .measure_sel_vbus(ms_v),
        .dac_threshold(dac_thr), .cc_source_current(cc_cur), .cc_current_level(level),
        .dac_cmp_status(dac_st), .vbus_valid(vbus_valid), .toggle_result_state(result),
        .irq_flags(flags), .int_n_o(int_n_o), .int_n_oe(int_n_oe));

    tccd_partner partner (.pullup_en_a(pu_a), .pullup_en_b(pu_b), .measure_sel_a(ms_a),
        .measure_sel_b(ms_b), .src_code(src_code), .src_on_b(src_on_b), .rd_en(rd_en),
        .rd_on_b(rd_on_b), .vbus_on(vbus_on), .level_cmp_raw(level_cmp_raw),
        .dac_cmp_raw(dac_cmp_raw), .vbus_valid_raw(vbus_valid_raw));

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic clr(input logic [3:0] v);
        irq_clear = v;
        step(1);
        irq_clear = 4'h0;
    endtask : clr

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({pd_a, pd_b, pu_a, pu_b, ms_a, ms_b, ms_v}, 8'h00);
        chk(cc_cur, 8'h01);
        chk({flags, int_n_oe}, 8'h00);
    endtask : t_reset

    task automatic t_manual;
        sw = 7'b0010101;
        sw_thr = 6'h2A;
        step(1);
        chk({pd_a, pd_b, pu_a, pu_b, ms_a, ms_b, ms_v}, sw);
        chk(dac_thr, 8'h2A);
        // open line under a pull-up drives the comparator high
        step(5);
        chk(dac_st, 8'h01);
        chk(level, 8'h00);
        chk(flags, 8'h02);
        chk({int_n_oe, int_n_o}, 8'h02);
        irq_mask = 4'h2;
        step(1);
        chk(int_n_oe, 8'h00);
        irq_mask = 4'h0;
        clr(4'h2);
        chk({flags, int_n_oe}, 8'h00);
    endtask : t_manual

    task automatic t_sink;
        sw = 7'b1100100;
        vbus_on = 1'b1;
        for (int c = 3; c >= 0; c--)
        begin
            src_code = 2'(c);
            step(2);
            // clear lands on the edge that sets the level flag: the set must win
            clr(4'h1);
            step(3);
            chk(level, 8'(c));
            chk(vbus_valid, 8'(c != 0));
            chk(flags[IRQ_LEVEL], 8'h01);
            // vbus only moves when the source arrives and when it leaves
            chk(flags[IRQ_VBUS], 8'((c == 3) || (c == 0)));
            clr(4'hF);
        end
        vbus_on = 1'b0;
        sw = 7'h0;
    endtask : t_sink

    task automatic t_current;
        rd_en = 1'b1;
        for (int s = 1; s <= 3; s++)
        begin
            cur_sel = 2'(s);
            step(1);
            chk(cc_cur, 8'(s));
        end
        rd_en = 1'b0;
    endtask : t_current

    task automatic t_toggle(input logic [1:0] mode, input logic [1:0] code,
        input logic on_b, input logic [2:0] exp, input logic [3:0] flg);
        int n;
        cur_sel = CUR_DEFAULT;
        irq_mask = 4'h7;
        src_code = code;
        src_on_b = on_b;
        rd_en = (code == 2'h0);
        rd_on_b = on_b;
        step(4);
        clr(4'hF);
        toggle_mode = mode;
        toggle_en = 1'b1;
        step(20);
        if (mode == MODE_SNK)
            chk({pu_a, pu_b, pd_a, pd_b}, 8'h03);
        else
        begin
            chk({pu_a, pu_b, pd_a, pd_b}, 8'h0C);
            chk(dac_thr, SRC_THRESH_LOW);
        end
        n = 0;
        while (result === RES_NONE && n < 6000)
        begin
            step(1);
            n++;
        end
        chk(result, exp);
        // comparator and level flags also record the phases walked through
        chk({flags, int_n_oe}, {3'h0, flg, 1'b1});
        toggle_en = 1'b0;
        step(2);
        chk(result, RES_NONE);
        clr(4'hF);
        src_code = 2'h0;
        rd_en = 1'b0;
    endtask : t_toggle

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            bad_count++;
            summarize();
        end
    end

    initial
    begin
        step(2);
        sys_rst = 1'b0;
        t_reset();
        t_manual();
        t_sink();
        t_current();
        t_toggle(MODE_DRP, 2'h0, 1'b1, RES_SRC_B, 4'hA);
        t_toggle(MODE_SRC, 2'h0, 1'b0, RES_SRC_A, 4'h8);
        t_toggle(MODE_SNK, 2'h2, 1'b1, RES_SNK_B, 4'h9);
        t_toggle(MODE_DRP, 2'h1, 1'b0, RES_SNK_A, 4'hB);
        summarize();
    end
endmodule : tb_top
